// [verilog/pcc_conv_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
`include "pcc_params.svh"
module pcc_conv_ctrl #(
  parameter logic [23:0] PER_10 = 24'(`PCC_CLK_HZ / `PCC_ODR_10_HZ),
  parameter logic [23:0] PER_50 = 24'(`PCC_CLK_HZ / `PCC_ODR_50_HZ),
  parameter logic [23:0] PER_60 = 24'(`PCC_CLK_HZ / `PCC_ODR_60_HZ),
  parameter logic [23:0] PER_120 = 24'(`PCC_CLK_HZ / `PCC_ODR_120_HZ)
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Configuration pins
  input wire logic rate_select_hi,
  input wire logic rate_select_lo,
  input wire logic gain_select_hi,
  input wire logic gain_select_lo,
  input wire logic input_pair_select,
  input wire logic temp_select,
  // Serial link
  input wire logic sclk,
  output logic dout_rdy,
  // Filter and modulator side
  input wire pcc_pkg::pcc_word_t filt_data,
  output logic mod_reset,
  output logic sel_first_input_pair,
  output logic sel_second_input_pair,
  output logic sel_temp,
  output logic [7:0] gain_value,
  output logic [6:0] notch_base_hz,
  output logic notch_extra_60,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import pcc_pkg::*;

  function automatic logic [23:0] rate_period(input pcc_rate_t r);
    case (r)
      `PCC_RATE_10: rate_period = PER_10;
      `PCC_RATE_50: rate_period = PER_50;
      `PCC_RATE_60: rate_period = PER_60;
      default: rate_period = PER_120;
    endcase
  endfunction

  function automatic logic [7:0] gain_of(input logic [1:0] g);
    case (g)
      2'h0: gain_of = `PCC_GAIN_1;
      2'h1: gain_of = `PCC_GAIN_8;
      2'h2: gain_of = `PCC_GAIN_64;
      default: gain_of = `PCC_GAIN_128;
    endcase
  endfunction

  // First notch sits at the output data rate, whatever the period parameters
  function automatic logic [6:0] notch_of(input pcc_rate_t r);
    case (r)
      `PCC_RATE_10: notch_of = 7'(`PCC_ODR_10_HZ);
      `PCC_RATE_50: notch_of = 7'(`PCC_ODR_50_HZ);
      `PCC_RATE_60: notch_of = 7'(`PCC_ODR_60_HZ);
      default: notch_of = 7'(`PCC_ODR_120_HZ);
    endcase
  endfunction

  // Two-flop synchronisers for every pin, sclk included
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= 7'h40; // Serial clock idles high, so no false edge after reset
      sync2_q <= 7'h40;
    end else begin
      sync1_q <= {sclk, temp_select, input_pair_select, gain_select_hi, gain_select_lo,
                  rate_select_hi, rate_select_lo};
      sync2_q <= sync1_q;
    end
  end

  wire pcc_rate_t rate_code = sync2_q[1:0];
  wire [1:0] gain_code = sync2_q[3:2];
  wire pair_hi = sync2_q[4];
  wire temp_on = sync2_q[5];
  wire sclk_s = sync2_q[6];

  // Previous sampled config; a power-up mismatch, present only when a config pin is high, acts as the start-up reset
  logic [5:0] cfg_prev_q;
  logic sclk_prev_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_prev_q <= 6'h00;
      sclk_prev_q <= 1'b1;
    end else begin
      cfg_prev_q <= sync2_q[5:0];
      sclk_prev_q <= sclk_s;
    end
  end

  // Change detection and restart sources
  wire cfg_change = sync2_q[5:0] != cfg_prev_q;
  wire apb_wr = psel & penable & pwrite;
  wire hit_ctrl = paddr == `PCC_REG_CTRL;
  wire hit_status = paddr == `PCC_REG_STATUS;
  wire hit_data = paddr == `PCC_REG_DATA;
  wire soft_restart = apb_wr & hit_ctrl & pwdata[`PCC_CTRL_RESTART];
  wire restart = cfg_change | soft_restart;
  wire sclk_fall = sclk_prev_q & ~sclk_s;
  wire sclk_rise = ~sclk_prev_q & sclk_s;

  // Conversion period timing at the selected rate
  logic [23:0] per_cnt_q;
  logic [2:0] settle_cnt_q;
  wire [23:0] period_sel = rate_period(rate_code);
  wire per_end = per_cnt_q == period_sel - 24'h00_0001;
  wire pre_high = per_cnt_q == period_sel - `PCC_PRE_HIGH_CYC;
  wire settled_now = settle_cnt_q >= `PCC_SETTLE_PERIODS - 3'h1;
  wire conv_done = per_end & ~restart & settled_now;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      per_cnt_q <= 24'h00_0000;
      settle_cnt_q <= 3'h0;
    end else if (restart) begin
      per_cnt_q <= 24'h00_0000;
      settle_cnt_q <= 3'h0;
    end else begin
      per_cnt_q <= per_end ? 24'h00_0000 : per_cnt_q + 24'h00_0001;
      if (per_end && settle_cnt_q < `PCC_SETTLE_PERIODS)
        settle_cnt_q <= settle_cnt_q + 3'h1;
    end
  end

  // Cycles since the last restart; only the settle-span check reads it
  logic [25:0] since_q;
  logic first_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      since_q <= 26'h000_0000;
      first_q <= 1'b1;
    end else if (restart) begin
      since_q <= 26'h000_0000;
      first_q <= 1'b1;
    end else begin
      since_q <= (&since_q) ? since_q : since_q + 26'h000_0001; // Saturates, never wraps
      if (conv_done)
        first_q <= 1'b0;
    end
  end
  wire [25:0] settle_span = {period_sel, 2'b00} - 26'h000_0001;

  // Result capture, offset binary from two's complement filter output
  pcc_word_t data_q;
  pcc_word_t shift_q;
  wire pcc_word_t ofs_bin = filt_data ^ `PCC_MSB_FLIP;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      data_q <= `PCC_DATA_RST;
    else if (conv_done)
      data_q <= ofs_bin;
  end

  // Serial output state; a pending read is simply lost on restart
  pcc_state_t state_q;
  logic dout_q;
  logic [4:0] bit_cnt_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_WAIT;
      dout_q <= 1'b1;
      bit_cnt_q <= 5'h00;
      shift_q <= `PCC_DATA_RST;
    end else if (restart) begin
      state_q <= ST_WAIT;
      dout_q <= 1'b1;
    end else if (conv_done) begin
      state_q <= ST_READY;
      dout_q <= 1'b0;
      bit_cnt_q <= 5'h00;
      shift_q <= ofs_bin;
    end else begin
      case (state_q)
        ST_READY, ST_SHIFT: begin
          if (pre_high) begin
            state_q <= ST_DONE;
            dout_q <= 1'b1;
          end else if (sclk_fall && bit_cnt_q < `PCC_BITS) begin
            state_q <= ST_SHIFT;
            dout_q <= shift_q[23];
            shift_q <= {shift_q[22:0], 1'b1};
            bit_cnt_q <= bit_cnt_q + 5'h01;
          end else if (sclk_rise && bit_cnt_q == `PCC_BITS) begin
            state_q <= ST_DONE;
            dout_q <= 1'b1;
          end
        end
        ST_WAIT, ST_DONE: dout_q <= 1'b1;
        default: state_q <= ST_WAIT;
      endcase
    end
  end
  assign dout_rdy = dout_q;

  // Modulator reset pulse and front-end selection
  logic mod_reset_q;
  logic sel_first_q;
  logic sel_second_q;
  logic sel_temp_q;
  logic [7:0] gain_q;
  logic [6:0] notch_q;
  logic notch60_q;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mod_reset_q <= 1'b1;
      sel_first_q <= 1'b0;
      sel_second_q <= 1'b0;
      sel_temp_q <= 1'b0;
      gain_q <= `PCC_GAIN_1;
      notch_q <= 7'h00;
      notch60_q <= 1'b0;
    end else begin
      mod_reset_q <= restart;
      sel_temp_q <= temp_on;
      sel_first_q <= ~temp_on & ~pair_hi;
      sel_second_q <= ~temp_on & pair_hi;
      gain_q <= gain_of(gain_code);
      // Filter order is fixed so every rate keeps over 53 dB stop band
      notch_q <= notch_of(rate_code);
      notch60_q <= rate_code == `PCC_RATE_50;
    end
  end
  assign mod_reset = mod_reset_q;
  assign sel_first_input_pair = sel_first_q;
  assign sel_second_input_pair = sel_second_q;
  assign sel_temp = sel_temp_q;
  assign gain_value = gain_q;
  assign notch_base_hz = notch_q;
  assign notch_extra_60 = notch60_q;

  // APB read data latched in the setup phase, zero wait states
  logic [31:0] prdata_q;
  wire [31:0] status_word = {24'h00_0000, temp_on, pair_hi, gain_code, rate_code,
                             state_q == ST_WAIT, dout_q};
  wire [31:0] rd_mux = hit_status ? status_word :
                       hit_data ? {8'h00, data_q} : 32'h0000_0000;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      prdata_q <= 32'h0000_0000;
    else if (psel && !penable)
      prdata_q <= rd_mux;
  end
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(hit_ctrl | hit_status | hit_data);

  // Checks
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_restart;
    restart;
  endsequence
  sequence s_held_high;
    dout_q && state_q == ST_WAIT;
  endsequence

  a_change_forces_high: assert property (s_restart |=> s_held_high)
    else $error("dout not forced high after restart");
  a_change_mod_reset: assert property (cfg_change |=> mod_reset)
    else $error("no modulator reset on config change");
  a_first_after_settle: assert property (conv_done |-> settle_cnt_q >= 3'h3)
    else $error("result before settling");
  a_restart_clears_settle: assert property (restart |=> settle_cnt_q == 3'h0 ##1 !conv_done)
    else $error("settle count not cleared");
  a_ready_low_data: assert property (conv_done |=> !dout_q && data_q == ($past(filt_data) ^ 24'h80_0000))
    else $error("ready or data wrong after conversion");
  a_wait_reads_ones: assert property (state_q == ST_WAIT && !conv_done |=> dout_q)
    else $error("wait state not reading ones");
  a_pre_update_high: assert property ((state_q == ST_READY) && pre_high && !restart && !conv_done |=> dout_q)
    else $error("dout not high before update");
  a_shift_msb: assert property (state_q == ST_READY && sclk_fall && !pre_high && !restart && !conv_done
                                |=> dout_q == $past(shift_q[23]))
    else $error("wrong bit shifted");
  a_temp_priority: assert property (temp_on |=> sel_temp && !sel_first_input_pair && !sel_second_input_pair)
    else $error("temperature select not dominant");
  a_notch_fifty: assert property (rate_code == 2'h2 |=> notch_extra_60)
    else $error("60 Hz notch missing at 50 Hz rate");
  a_settle_span: assert property (conv_done && first_q |-> since_q == settle_span)
    else $error("first result not four periods after restart");
  a_pair_decode: assert property (!temp_on && pair_hi |=> sel_second_input_pair && !sel_first_input_pair)
    else $error("second input pair not selected");
  a_gain_max: assert property (gain_code == 2'h3 |=> gain_value == 8'h80)
    else $error("gain 128 not decoded");
  a_gain_eight: assert property (gain_code == 2'h1 |=> gain_value == 8'h08)
    else $error("gain 8 not decoded");
  a_notch_base: assert property (rate_code == 2'h0 |=> notch_base_hz == 7'h78)
    else $error("notch not at 120 Hz rate");
  a_notch_ten: assert property (rate_code == 2'h3 |=> notch_base_hz == 7'h0A)
    else $error("notch not at 10 Hz rate");
  a_bits_then_high: assert property (state_q == ST_SHIFT && sclk_rise && bit_cnt_q == `PCC_BITS && !pre_high
                                     && !restart && !conv_done |=> dout_q && state_q == ST_DONE)
    else $error("dout not high after last bit");
endmodule // pcc_conv_ctrl
`default_nettype wire

// [verilog/pcc_params.svh]
`ifndef PCC_PARAMS_SVH
`define PCC_PARAMS_SVH
`define PCC_CLK_HZ 100000000
`define PCC_ODR_10_HZ 10
`define PCC_ODR_50_HZ 50
`define PCC_ODR_60_HZ 60
`define PCC_ODR_120_HZ 120
`define PCC_RATE_10 2'h3
`define PCC_RATE_50 2'h2
`define PCC_RATE_60 2'h1
`define PCC_RATE_120 2'h0
`define PCC_GAIN_1 8'h01
`define PCC_GAIN_8 8'h08
`define PCC_GAIN_64 8'h40
`define PCC_GAIN_128 8'h80
`define PCC_SETTLE_PERIODS 3'h4
`define PCC_PRE_HIGH_CYC 24'h00_0010
`define PCC_DATA_W 24
`define PCC_BITS 5'h18
`define PCC_MSB_FLIP 24'h80_0000
`define PCC_REG_CTRL 8'h00
`define PCC_REG_STATUS 8'h04
`define PCC_REG_DATA 8'h08
`define PCC_CTRL_RESTART 0
`define PCC_DATA_RST 24'h00_0000
`endif

// [verilog/pcc_pkg.sv]
`default_nettype none
package pcc_pkg;
  typedef logic [1:0] pcc_rate_t;
  typedef logic [23:0] pcc_word_t;
  typedef enum logic [1:0] {ST_WAIT, ST_READY, ST_SHIFT, ST_DONE} pcc_state_t;
endpackage
`default_nettype wire

// [tb/pcc_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module pcc_host_model (
  // Serial link
  output logic sclk,
  input wire logic dout
);
  // Clock stands high between frames
  initial sclk = 1'b1;

  // Pulls one 24-bit word, MSB first
  task automatic read_word(output logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      #80 sclk = 1'b0;
      #80 sclk = 1'b1;
      w[i] = dout;
    end
  endtask
endmodule // pcc_host_model
`default_nettype wire

// [tb/pin_config_conversion_control_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
module pin_config_conversion_control_tb_top;
  import pcc_pkg::*;
  // Short periods keep settling inside the run
  localparam int P[4] = '{800, 700, 650, 600};
  logic clk, nrst, rhi, rlo, ghi, glo, pair, temp, sclk, dout_rdy, psel, penable, pwrite;
  logic pready, pslverr, x60, s1, s2, st, er, mr;
  logic [7:0] paddr, gv;
  logic [6:0] nb;
  logic [31:0] pwdata, prdata, rd;
  logic [23:0] w;
  pcc_word_t filt;
  int n_errors = 0, total_checks = 0, cyc = 0, c0;
  // Rows: rate code, gain code, gain, base notch in Hz, extra notch
  logic [19:0] rows[4] = '{{2'h3, 2'h0, 8'h01, 7'h0A, 1'b0}, {2'h2, 2'h1, 8'h08, 7'h32, 1'b1},
                          {2'h1, 2'h2, 8'h40, 7'h3C, 1'b0}, {2'h0, 2'h3, 8'h80, 7'h78, 1'b0}};

  pcc_conv_ctrl #(.PER_10(24'd800), .PER_50(24'd700), .PER_60(24'd650), .PER_120(24'd600)) u_dut (
    .clk(clk), .nrst(nrst), .rate_select_hi(rhi), .rate_select_lo(rlo), .gain_select_hi(ghi),
    .gain_select_lo(glo), .input_pair_select(pair), .temp_select(temp), .sclk(sclk), .dout_rdy(dout_rdy),
    .filt_data(filt), .mod_reset(mr), .sel_first_input_pair(s1), .sel_second_input_pair(s2), .sel_temp(st),
    .gain_value(gv), .notch_base_hz(nb), .notch_extra_60(x60), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
  pcc_host_model u_host (.sclk(sclk), .dout(dout_rdy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard well above the expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // Sampled on the falling clock so register updates have landed
  task automatic wait_dout(input logic v);
    @(negedge clk);
    while (dout_rdy !== v) @(negedge clk);
  endtask

  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic results();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    {nrst, rhi, rlo, ghi, glo, pair, temp, psel, penable, pwrite} = '0;
    paddr = '0;
    pwdata = '0;
    filt = 24'h12_3456;
    repeat (12) @(posedge clk);
    chk("dout in reset", dout_rdy, 1);
    chk("gain in reset", gv, 8'h01);
    nrst <= 1'b1;
    // Each row restarts and must wait four periods
    foreach (rows[i]) begin
      @(posedge clk);
      {rhi, rlo, ghi, glo} <= rows[i][19:16];
      c0 = cyc;
      repeat (4) @(negedge clk);
      chk("mod reset", mr, 1);
      @(negedge clk);
      chk("mod reset end", mr, 0);
      @(negedge clk);
      chk("dout forced", dout_rdy, 1);
      wait_dout(1'b0);
      chk("settle", 32'(cyc - c0 >= 4 * P[i] && cyc - c0 <= 4 * P[i] + 8), 1);
      chk("gain", gv, rows[i][15:8]);
      chk("notch", nb, rows[i][7:1]);
      chk("notch60", x60, rows[i][0]);
      u_host.read_word(w);
      chk("word", w, 24'h92_3456);
      repeat (6) @(negedge clk);
      chk("dout after read", dout_rdy, 1);
    end
    @(posedge clk);
    apb(1'b0, 8'h08, '0);
    chk("data reg", rd, 32'h0092_3456);
    @(posedge clk);
    apb(1'b0, 8'h04, '0);
    chk("status", rd, 32'h0000_0031);
    @(posedge clk);
    apb(1'b1, 8'h0C, 32'hFFFF_FFFF);
    chk("unmapped", {rd[30:0], er}, 32'h0000_0001);
    // Pair change after the read; reads while settling give ones
    @(posedge clk);
    pair <= 1'b1;
    repeat (6) @(negedge clk);
    chk("pair", {s1, s2, st}, 3'b010);
    u_host.read_word(w);
    chk("read settling", w, 24'hFF_FFFF);
    @(posedge clk);
    temp <= 1'b1;
    filt <= 24'hFF_FFFF;
    repeat (6) @(negedge clk);
    chk("temp", {s1, s2, st}, 3'b001);
    // First result after the step is left unread; the next one must carry the new input
    wait_dout(1'b0);
    c0 = cyc;
    @(posedge clk);
    filt <= 24'h00_0001;
    repeat (P[3] - 10) @(negedge clk);
    chk("pre high", dout_rdy, 1);
    wait_dout(1'b0);
    chk("period", cyc - c0, P[3]);
    @(posedge clk);
    apb(1'b0, 8'h08, '0);
    chk("data update", rd, 32'h0080_0001);
    @(negedge clk);
    chk("ready before restart", dout_rdy, 0);
    // Soft restart while a result waits forces the output high
    @(posedge clk);
    apb(1'b1, 8'h00, 32'h0000_0001);
    chk("restart err", er, 0);
    @(negedge clk);
    chk("soft restart", dout_rdy, 1);
    @(posedge clk);
    apb(1'b0, 8'h04, '0);
    chk("status wait", rd, 32'h0000_00F3);
    // Reset in mid-run: outputs return to reset values, then the pins restart the filter
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(negedge clk);
    chk("gain in mid reset", gv, 8'h01);
    chk("mod reset in reset", mr, 1);
    @(posedge clk);
    nrst <= 1'b1;
    c0 = cyc;
    wait_dout(1'b0);
    chk("settle after reset", 32'(cyc - c0 >= 4 * P[3] && cyc - c0 <= 4 * P[3] + 8), 1);
    results();
  end
endmodule // pin_config_conversion_control_tb_top
`default_nettype wire
